/* File: rtl/dfc_pkg.sv */
package dfc_pkg;

  // Structure of the block.
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  localparam int REG_W  = 16;
  localparam int ADDR_W = 8;
  localparam int CYC_W  = 18;
  localparam int IDX_W  = 6;

  // Register addresses on the serial register port.
  localparam logic [ADDR_W-1:0] CFG_ADDR [NUM_CH] =
    '{8'h06, 8'h0C, 8'h12, 8'h18};
  localparam logic [ADDR_W-1:0] DATA_ADDR [NUM_CH] =
    '{8'h19, 8'h1A, 8'h1B, 8'h1C};
  localparam logic [ADDR_W-1:0] TRIG_ADDR = 8'h20;

  // Reset value of each channel_function_config register.
  localparam logic [REG_W-1:0] CFG_RST = 16'h0000;

  // Field positions in channel_function_config.
  localparam int CLR_SEL_BIT = 15;
  localparam int SYNC_BIT    = 14;
  localparam int BRD_BIT     = 13;
  localparam int PHASE_LSB   = 11;
  localparam int FUNC_LSB    = 8;
  localparam int LOG_BIT     = 7;
  localparam int STEP_LSB    = 4;
  localparam int RATE_LSB    = 0;
  localparam int RISE_LSB    = 4;
  localparam int FALL_LSB    = 1;
  localparam int DATA_LSB    = 4;

  // Field positions in the trigger register.
  localparam int TRIG_LD_BIT  = 7;
  localparam int TRIG_CLR_BIT = 6;

  // Codes loaded by a clear and the first code of a logarithmic slew up from zero.
  localparam logic [CODE_W-1:0] ZERO_CODE    = 12'h000;
  localparam logic [CODE_W-1:0] MID_CODE     = 12'h800;
  localparam logic [CODE_W-1:0] LOG_MIN_CODE = 12'h001;

  // A shift of five is the 0.03125 ratio of a logarithmic step.
  localparam int LOG_SHIFT = 5;

  // Waveform type codes.
  localparam logic [2:0] FN_TRI  = 3'h0;
  localparam logic [2:0] FN_SAW  = 3'h1;
  localparam logic [2:0] FN_ISAW = 3'h2;
  localparam logic [2:0] FN_SINE = 3'h4;

  // Start index in a 64-point cycle for 0, 120, 240 and 90 degrees.
  localparam logic [IDX_W-1:0] PHASE_IDX [4] =
    '{6'h00, 6'h15, 6'h2B, 6'h10};

  // Linear code increment per step.
  localparam logic [5:0] LIN_STEP [8] =
    '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};

  // Step intervals in microseconds; code zero of the linear set is unused.
  localparam int  CLK_MHZ = 40;
  localparam real LIN_US [16] = '{0.0, 4.0, 8.0, 12.0, 18.0, 27.04,
    40.48, 60.72, 91.12, 136.72, 239.2, 336.72, 418.64, 1282.0,
    2564.0, 5127.92};
  localparam real LOG_US [8] = '{4.0, 12.0, 27.04, 60.72, 136.72,
    418.64, 1282.0, 5127.92};

  // Cycles for an interval, rounded down and never below one.
  function automatic int us_to_cyc(real us);
    int c;
    c = $rtoi(us * CLK_MHZ);
    return (c < 1) ? 1 : c;
  endfunction

  // Channel activity, one-hot.
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_SLEW = 3'b010,
    MODE_WAVE = 3'b100
  } dfc_mode_e;

endpackage

/* File: rtl/dfc_step_timer.sv */
`timescale 1ns/1ps
module dfc_step_timer
  import dfc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Control.
  input  wire logic             en_i,
  input  wire logic             restart_i,
  input  wire logic [CYC_W-1:0] period_i,
  // Step event.
  output logic                  tick_o
);

  // Whole state of the timer.
  typedef struct packed {
    logic [CYC_W-1:0] cnt;  // Cycles since the last step.
    logic             tick; // One-cycle step pulse.
  } dfc_tmr_s;

  dfc_tmr_s q;
  dfc_tmr_s d;

  // A new period takes effect at once; a count already past it wraps on the
  // next cycle, so a change never produces a step shorter than the new interval.
  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (!en_i || restart_i)
    begin
      // Held at zero while idle so the first step is a full interval.
      d.cnt = '0;
    end
    else if (q.cnt >= period_i - 18'h00001)
    begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 18'h00001;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign tick_o = q.tick;

endmodule

/* File: rtl/dfc_sine_rom.sv */
`timescale 1ns/1ps
module dfc_sine_rom
  import dfc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Lookup.
  input  wire logic [IDX_W-1:0] idx_i,
  output logic      [7:0]       shape_o
);

  // Quarter wave, amplitude 127 about a midpoint of 128.
  localparam logic [6:0] QTAB [16] = '{7'h00, 7'h0C, 7'h19, 7'h25,
    7'h31, 7'h3C, 7'h47, 7'h51, 7'h5A, 7'h62, 7'h6A, 7'h70, 7'h75,
    7'h7A, 7'h7D, 7'h7E};

  // Whole state of the table read port.
  typedef struct packed {
    logic [7:0] shape; // Registered sample.
  } dfc_rom_s;

  dfc_rom_s   q;
  dfc_rom_s   d;
  logic [3:0] k;   // Index into the quarter table.

  // Mirror the quarter wave; the upper half lies below the midpoint.
  always_comb
  begin
    d = q;
    k = idx_i[4] ? ~idx_i[3:0] : idx_i[3:0];
    if (idx_i[5])
      d.shape = 8'h80 - {1'b0, QTAB[k]};
    else
      d.shape = 8'h80 + {1'b0, QTAB[k]};
  end

  // Read register.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign shape_o = q.shape;

endmodule

/* File: rtl/dfc_func_config.sv */
`timescale 1ns/1ps
module dfc_func_config
  import dfc_pkg::*;
#(
  parameter int INTERVAL_DIV = 1
)
(
  // Clock and reset.
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  // Serial register port, already deframed.
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  input  wire logic [ADDR_W-1:0]              reg_addr_i,
  input  wire logic [REG_W-1:0]               reg_wdata_i,
  output logic      [REG_W-1:0]               reg_rdata_o,
  output logic                                reg_rvalid_o,
  // Broadcast data write.
  input  wire logic                           brd_wr_i,
  input  wire logic [CODE_W-1:0]              brd_data_i,
  // Pins, active low events on the falling edge.
  input  wire logic                           load_update_trigger_n_i,
  input  wire logic                           clear_trigger_n_i,
  // Margin codes and the margin level selection per channel.
  input  wire logic [NUM_CH-1:0][CODE_W-1:0]  margin_low_i,
  input  wire logic [NUM_CH-1:0][CODE_W-1:0]  margin_high_i,
  input  wire logic [NUM_CH-1:0]              margin_high_sel_i,
  // Channel outputs.
  output logic      [NUM_CH-1:0][CODE_W-1:0]  dac_code_o,
  output logic      [NUM_CH-1:0]              slew_busy_o
);

  // Whole state of the block.
  typedef struct packed {
    logic      [NUM_CH-1:0][REG_W-1:0]  cfg;       // Config registers.
    logic      [NUM_CH-1:0][CODE_W-1:0] code;      // Output codes.
    logic      [NUM_CH-1:0][CODE_W-1:0] pend;      // Held sync data.
    logic      [NUM_CH-1:0]             pend_v;    // Held data valid.
    logic      [NUM_CH-1:0][CODE_W-1:0] tgt;       // Slew target.
    dfc_mode_e [NUM_CH-1:0]             mode;      // Channel activity.
    logic      [NUM_CH-1:0][IDX_W-1:0]  widx;      // Waveform index.
    logic      [NUM_CH-1:0]             busy;      // Slew in progress.
    logic      [NUM_CH-1:0]             sel_prev;  // Last margin select.
    logic                               ldn_prev;  // Last load pin.
    logic                               clrn_prev; // Last clear pin.
    logic                               trig_ld;   // Software load.
    logic                               trig_clr;  // Software clear.
    logic      [REG_W-1:0]              rdata;     // Read data.
    logic                               rvalid;    // Read strobe.
  } dfc_state_s;

  dfc_state_s q;
  dfc_state_s d;

  // Interval tables in clock cycles, shortened by INTERVAL_DIV.
  logic [CYC_W-1:0] lin_tab [16];
  logic [CYC_W-1:0] log_tab [8];

  // Per-channel helpers computed from the registered state.
  logic [NUM_CH-1:0][CODE_W-1:0] nxt_up;    // Next code slewing up.
  logic [NUM_CH-1:0][CODE_W-1:0] nxt_dn;    // Next code slewing down.
  logic [NUM_CH-1:0][CODE_W-1:0] wave_code; // Waveform sample.
  logic [NUM_CH-1:0]             go_up;     // Current is below target.
  logic [NUM_CH-1:0]             wave_ok;   // Valid waveform set up.
  logic [NUM_CH-1:0]             no_slew;   // Linear rate code zero.
  logic [NUM_CH-1:0]             tick;      // Step interval elapsed.
  logic [NUM_CH-1:0]             restart;   // Start a fresh interval.

  // Table entries are fixed at elaboration from the printed times.
  for (genvar k = 0; k < 16; k++)
  begin : g_lin
    localparam int C = us_to_cyc(LIN_US[k]) / INTERVAL_DIV;
    assign lin_tab[k] = CYC_W'((C < 1) ? 1 : C);
  end

  for (genvar k = 0; k < 8; k++)
  begin : g_log
    localparam int C = us_to_cyc(LOG_US[k]) / INTERVAL_DIV;
    assign log_tab[k] = CYC_W'((C < 1) ? 1 : C);
  end

  // Step arithmetic, interval selection and waveform shaping per channel.
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [REG_W-1:0]  cf;      // This channel's config.
    logic [CODE_W-1:0] cur;     // Present output code.
    logic [CODE_W:0]   inc;     // Step size with headroom.
    logic [CODE_W:0]   inc_lg;  // Logarithmic step size.
    logic [CODE_W:0]   sum;     // Code plus step.
    logic [CODE_W:0]   dif;     // Code minus step.
    logic              up_dir;  // Direction for the interval choice.
    logic [2:0]        fn;      // Waveform type.
    logic [CODE_W-1:0] base;    // Lower margin.
    logic [CODE_W-1:0] span;    // Distance between margins.
    logic [7:0]        shape;   // Sample on a 0 to 255 scale.
    logic [7:0]        sine;    // Sine table sample.
    logic [19:0]       prod;    // Span times sample.
    logic [CYC_W-1:0]  period;  // Active interval.

    assign cf      = q.cfg[c];
    assign cur     = q.code[c];
    assign fn      = cf[FUNC_LSB +: 3];
    assign go_up[c] = cur < q.tgt[c];

    assign inc_lg = ((cur >> LOG_SHIFT) == 12'h000) ? 13'h0001
                  : {1'b0, cur >> LOG_SHIFT};
    assign inc = cf[LOG_BIT] ? inc_lg
               : {7'h00, LIN_STEP[cf[STEP_LSB +: 3]]};
    assign sum = {1'b0, cur} + inc;
    assign dif = {1'b0, cur} - inc;

    assign nxt_up[c] = (cf[LOG_BIT] && cur == ZERO_CODE) ? LOG_MIN_CODE
                     : (sum >= {1'b0, q.tgt[c]}) ? q.tgt[c]
                     : sum[CODE_W-1:0];
    assign nxt_dn[c] = (dif[CODE_W] || dif[CODE_W-1:0] <= q.tgt[c])
                     ? q.tgt[c] : dif[CODE_W-1:0];

    assign no_slew[c] = !cf[LOG_BIT] && cf[RATE_LSB +: 4] == 4'h0;

    assign wave_ok[c] = !no_slew[c] && (fn == FN_TRI || fn == FN_SAW ||
                        fn == FN_ISAW || fn == FN_SINE);

    // With logarithmic timing a waveform takes the rise interval in the first half of its cycle and the fall interval in the second.
    assign up_dir = (q.mode[c] == MODE_WAVE) ? ~q.widx[c][IDX_W-1]
                  : go_up[c];

    assign period = !cf[LOG_BIT] ? lin_tab[cf[RATE_LSB +: 4]]
                  : up_dir ? log_tab[cf[RISE_LSB +: 3]]
                  : log_tab[cf[FALL_LSB +: 3]];

    // Margins may be set either way round; the wave spans them both.
    assign base = (margin_low_i[c] < margin_high_i[c]) ? margin_low_i[c]
                : margin_high_i[c];
    assign span = (margin_low_i[c] < margin_high_i[c])
                ? margin_high_i[c] - margin_low_i[c]
                : margin_low_i[c] - margin_high_i[c];

    // Shapes of the four waveforms from the cycle index.
    always_comb
    begin
      unique case (fn)
        FN_TRI:  shape = q.widx[c][5] ? {~q.widx[c][4:0], 3'h0}
                                      : {q.widx[c][4:0], 3'h0};
        FN_SAW:  shape = {q.widx[c], 2'h0};
        FN_ISAW: shape = ~{q.widx[c], 2'h0};
        default: shape = sine;
      endcase
    end

    // Sample never exceeds 255/256 of the span, so the sum cannot wrap.
    assign prod         = span * shape;
    assign wave_code[c] = base + prod[19:8];

    dfc_sine_rom u_sine (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .idx_i     (q.widx[c]),
      .shape_o   (sine)
    );

    dfc_step_timer u_timer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (q.mode[c] != MODE_IDLE),
      .restart_i (restart[c]),
      .period_i  (period),
      .tick_o    (tick[c])
    );
  end

  // Register access, triggers and per-channel sequencing.
  always_comb
  begin
    logic              load_all;  // Pin or software load event.
    logic              clear_all; // Pin or software clear event.
    logic              has_val;   // New data for this channel.
    logic [CODE_W-1:0] val;       // The new data.
    logic              wr_cfg;    // Config write to this channel.
    load_all  = 1'b0;
    clear_all = 1'b0;
    has_val   = 1'b0;
    val       = '0;
    wr_cfg    = 1'b0;

    d           = q;
    d.rvalid    = reg_rd_i;
    d.ldn_prev  = load_update_trigger_n_i;
    d.clrn_prev = clear_trigger_n_i;
    d.sel_prev  = margin_high_sel_i;
    restart     = '0;

    // Trigger bits live one cycle: set by a write, acted on, then gone.
    d.trig_ld  = reg_wr_i && reg_addr_i == TRIG_ADDR &&
                 reg_wdata_i[TRIG_LD_BIT];
    d.trig_clr = reg_wr_i && reg_addr_i == TRIG_ADDR &&
                 reg_wdata_i[TRIG_CLR_BIT];

    load_all  = (q.ldn_prev && !load_update_trigger_n_i) || q.trig_ld;
    clear_all = (q.clrn_prev && !clear_trigger_n_i) || q.trig_clr;

    // Unmapped addresses read as zero.
    if (reg_rd_i)
    begin
      d.rdata = '0;
      if (reg_addr_i == TRIG_ADDR)
      begin
        d.rdata[TRIG_LD_BIT]  = q.trig_ld;
        d.rdata[TRIG_CLR_BIT] = q.trig_clr;
      end
    end

    for (int c = 0; c < NUM_CH; c++)
    begin
      wr_cfg = reg_wr_i && reg_addr_i == CFG_ADDR[c];

      // Register read-back of config and of the live output code.
      if (reg_rd_i && reg_addr_i == CFG_ADDR[c])
        d.rdata = q.cfg[c];
      if (reg_rd_i && reg_addr_i == DATA_ADDR[c])
        d.rdata = {q.code[c], 4'h0};

      has_val = (reg_wr_i && reg_addr_i == DATA_ADDR[c]) ||
                (brd_wr_i && q.cfg[c][BRD_BIT]);
      val     = (reg_wr_i && reg_addr_i == DATA_ADDR[c])
              ? reg_wdata_i[DATA_LSB +: CODE_W] : brd_data_i;

      // Channel activity.
      unique case (q.mode[c])
        MODE_IDLE:
        begin
          if (wave_ok[c])
          begin
            d.mode[c]  = MODE_WAVE;
            d.widx[c]  = PHASE_IDX[q.cfg[c][PHASE_LSB +: 2]];
            restart[c] = 1'b1;
          end
        end
        MODE_SLEW:
        begin
          if (wave_ok[c])
          begin
            d.mode[c]  = MODE_WAVE;
            d.widx[c]  = PHASE_IDX[q.cfg[c][PHASE_LSB +: 2]];
            restart[c] = 1'b1;
          end
          else if (q.code[c] == q.tgt[c])
            d.mode[c] = MODE_IDLE;
          else if (tick[c])
          begin
            d.code[c] = go_up[c] ? nxt_up[c] : nxt_dn[c];
            if (d.code[c] == q.tgt[c])
              d.mode[c] = MODE_IDLE;
          end
        end
        MODE_WAVE:
        begin
          if (!wave_ok[c])
            d.mode[c] = MODE_IDLE;
          else
          begin
            d.code[c] = wave_code[c];
            if (tick[c])
              d.widx[c] = q.widx[c] + 6'h01;
          end
        end
        default:
          d.mode[c] = MODE_IDLE;
      endcase

      // A margin select change starts a slew, or jumps straight to target at linear rate code zero, unless a waveform owns the output.
      if (margin_high_sel_i[c] != q.sel_prev[c] && q.mode[c] != MODE_WAVE)
      begin
        d.tgt[c] = margin_high_sel_i[c] ? margin_high_i[c]
                                        : margin_low_i[c];
        if (no_slew[c])
        begin
          d.code[c] = d.tgt[c];
          d.mode[c] = MODE_IDLE;
        end
        else
        begin
          d.mode[c]  = MODE_SLEW;
          restart[c] = 1'b1;
        end
      end

      if (load_all && q.pend_v[c] && q.cfg[c][SYNC_BIT])
      begin
        d.code[c]   = q.pend[c];
        d.pend_v[c] = 1'b0;
      end

      if (has_val && !q.cfg[c][SYNC_BIT])
      begin
        d.code[c] = val;
        if (q.mode[c] == MODE_SLEW)
          d.mode[c] = MODE_IDLE;
      end
      else if (has_val)
      begin
        d.pend[c]   = val;
        d.pend_v[c] = 1'b1;
      end

      // A config write re-arms the waveform so a new phase takes effect.
      if (wr_cfg)
      begin
        d.cfg[c]  = reg_wdata_i;
        d.mode[c] = MODE_IDLE;
      end

      if (clear_all)
      begin
        d.code[c]   = q.cfg[c][CLR_SEL_BIT] ? MID_CODE : ZERO_CODE;
        d.pend[c]   = d.code[c];
        d.pend_v[c] = 1'b0;
        if (q.mode[c] == MODE_SLEW)
          d.mode[c] = MODE_IDLE;
      end

      d.busy[c] = d.mode[c] == MODE_SLEW;
    end
  end

  // State register; pin history starts high so reset is no edge.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q           <= '0;
      q.cfg       <= {NUM_CH{CFG_RST}};
      q.mode      <= '{default: MODE_IDLE};
      q.ldn_prev  <= 1'b1;
      q.clrn_prev <= 1'b1;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register.
  assign reg_rdata_o  = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign dac_code_o   = q.code;
  assign slew_busy_o  = q.busy;

endmodule

/* File: dv/dfc_func_config_properties.sv */
`timescale 1ns/1ps
module dfc_func_config_properties
  import dfc_pkg::*;
#(
  parameter int INTERVAL_DIV = 1
)
(
  // Clock and reset.
  input wire logic                          clk_i,
  input wire logic                          sys_rst_i,
  // Register port.
  input wire logic                          reg_wr_i,
  input wire logic                          brd_wr_i,
  input wire logic                          reg_rd_i,
  input wire logic [ADDR_W-1:0]             reg_addr_i,
  input wire logic [REG_W-1:0]              reg_wdata_i,
  input wire logic [REG_W-1:0]              reg_rdata_o,
  input wire logic                          reg_rvalid_o,
  // Pins, margins and outputs.
  input wire logic                          load_update_trigger_n_i,
  input wire logic                          clear_trigger_n_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] margin_low_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] margin_high_i,
  input wire logic [NUM_CH-1:0]             margin_high_sel_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o,
  input wire logic [NUM_CH-1:0]             slew_busy_o
);
  // Mirror of the channel 0 update mode, taken from config writes.
  logic sync0_q;
  logic trig_ld;
  logic trig_clr;
  assign trig_ld  = reg_wr_i && reg_addr_i == TRIG_ADDR && reg_wdata_i[7];
  assign trig_clr = reg_wr_i && reg_addr_i == TRIG_ADDR && reg_wdata_i[6];
  // Reset with the block, so the two always agree.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      sync0_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i == CFG_ADDR[0])
      sync0_q <= reg_wdata_i[SYNC_BIT];
  end
  // True when every channel shows one of the two clear codes.
  function automatic logic all_clr(logic [NUM_CH-1:0][CODE_W-1:0] c);
    all_clr = 1'b1;
    for (int i = 0; i < NUM_CH; i++)
      all_clr &= (c[i] == ZERO_CODE) || (c[i] == MID_CODE);
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_clr_req;
    trig_clr;
  endsequence
  sequence s_cleared;
    all_clr(dac_code_o);
  endsequence
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved");
  a_trig_clear: assert property (s_clr_req |-> ##2 s_cleared)
    else $error("clear trigger not applied");
  a_pin_clear: assert property (
    $fell(clear_trigger_n_i) |=> s_cleared)
    else $error("clear pin not applied");
  a_write_direct: assert property (
    reg_wr_i && reg_addr_i == DATA_ADDR[0] && !sync0_q &&
    !$fell(clear_trigger_n_i) && !$past(trig_clr) |=>
    dac_code_o[0] == CODE_W'($past(reg_wdata_i) >> DATA_LSB))
    else $error("direct write not applied");
  a_sync_holds: assert property (
    reg_wr_i && reg_addr_i == DATA_ADDR[0] && sync0_q &&
    !$fell(load_update_trigger_n_i) && !$fell(clear_trigger_n_i) &&
    !$past(trig_clr) && !$past(trig_ld) |=> $stable(dac_code_o[0]))
    else $error("held write reached output");
  a_busy_cause: assert property (
    $rose(slew_busy_o[3]) |->
    $past(margin_high_sel_i[3]) != $past(margin_high_sel_i[3], 2))
    else $error("slew without select change");
  a_busy_target: assert property (
    $fell(slew_busy_o[3]) && !$past(reg_wr_i || brd_wr_i) &&
    $past(clear_trigger_n_i) && !$past(trig_clr, 2)
    |-> dac_code_o[3] == (margin_high_sel_i[3] ? margin_high_i[3] :
    margin_low_i[3]))
    else $error("slew ended off target");
  a_log_rising: assert property (
    slew_busy_o[2] && $past(slew_busy_o[2]) && margin_high_sel_i[2] &&
    $stable(margin_high_sel_i[2]) |-> dac_code_o[2] >= $past(dac_code_o[2])
    && dac_code_o[2] <= margin_high_i[2])
    else $error("rising slew went wrong way");
endmodule

bind dfc_func_config dfc_func_config_properties #(
  .INTERVAL_DIV(INTERVAL_DIV)) chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .brd_wr_i(brd_wr_i),
  .load_update_trigger_n_i(load_update_trigger_n_i),
  .clear_trigger_n_i(clear_trigger_n_i), .margin_low_i(margin_low_i),
  .margin_high_i(margin_high_i), .margin_high_sel_i(margin_high_sel_i),
  .dac_code_o(dac_code_o), .slew_busy_o(slew_busy_o));

/* File: dv/dfc_host_model.sv */
`timescale 1ns/1ps
module dfc_host_model
  import dfc_pkg::*;
(
  // Clock.
  input  wire logic                          clk_i,
  // Register port and broadcast.
  output logic                               wr_o,
  output logic                               rd_o,
  output logic      [ADDR_W-1:0]             addr_o,
  output logic      [REG_W-1:0]              wdata_o,
  input  wire logic [REG_W-1:0]              rdata_i,
  input  wire logic                          rvalid_i,
  output logic                               brd_o,
  output logic      [CODE_W-1:0]             bdata_o,
  // Pins and margin levels.
  output logic      [1:0]                    pin_n_o,
  output logic      [NUM_CH-1:0][CODE_W-1:0] lo_o,
  output logic      [NUM_CH-1:0][CODE_W-1:0] hi_o,
  output logic      [NUM_CH-1:0]             sel_o
);
  // Pins idle high so no event is seen at reset release.
  initial
  begin
    {wr_o, rd_o, brd_o, addr_o, wdata_o, bdata_o} = '0;
    pin_n_o = 2'b11;
    {lo_o, hi_o, sel_o} = '0;
  end
  // One write; released lines show the inverse.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(posedge clk_i);
    #1;
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  // One read; data and valid are taken one edge after the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_i);
    #1;
    {rd_o, addr_o} = {1'b1, a};
    @(posedge clk_i);
    #1;
    {rd_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
    v = rvalid_i;
  endtask
  // Broadcast data pulse.
  task automatic brd(input logic [11:0] d);
    @(posedge clk_i);
    #1;
    {brd_o, bdata_o} = {1'b1, d};
    @(posedge clk_i);
    #1;
    {brd_o, bdata_o} = {1'b0, ~d};
  endtask
  // Falling edge on pin 0 (load) or 1 (clear), held low two edges.
  task automatic pin(input int p);
    @(posedge clk_i);
    #1;
    pin_n_o[p] = 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    pin_n_o[p] = 1'b1;
  endtask
  // New margin codes and select for one channel.
  task automatic marg(input int c, input logic [11:0] l, h, input logic s);
    @(posedge clk_i);
    #1;
    {lo_o[c], hi_o[c], sel_o[c]} = {l, h, s};
  endtask
endmodule

/* File: dv/dfc_func_config_tb.sv */
`timescale 1ns/1ps
module dfc_func_config_tb
  import dfc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rd, brd, rv, v;
  logic [1:0] pn;
  logic [7:0] addr;
  logic [15:0] wd, rdat, d;
  logic [11:0] bd;
  logic [3:0][11:0] ml, mh, code;
  logic [3:0] sel, busy;
  int fail_count = 0;
  int tests_run = 0;
  // One cycle per microsecond of interval.
  dfc_func_config #(.INTERVAL_DIV(40)) dut_u (.clk_i(clk), .sys_rst_i(rst),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .brd_wr_i(brd), .brd_data_i(bd),
    .load_update_trigger_n_i(pn[0]), .clear_trigger_n_i(pn[1]),
    .margin_low_i(ml), .margin_high_i(mh), .margin_high_sel_i(sel),
    .dac_code_o(code), .slew_busy_o(busy));
  dfc_host_model h (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv), .brd_o(brd), .bdata_o(bd),
    .pin_n_o(pn), .lo_o(ml), .hi_o(mh), .sel_o(sel));
  // 40 MHz clock.
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Follows a slew step by step; a zero step means logarithmic.
  task automatic track(input int ch, tgt, stp, per);
    int e, dl, gap, cnt;
    logic [11:0] prev;
    e = code[ch];
    prev = code[ch];
    gap = 0;
    cnt = 0;
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      #1;
      gap++;
      if (code[ch] !== prev)
      begin
        cnt++;
        dl = (stp > 0) ? stp : (((e >> 5) > 0) ? (e >> 5) : 1);
        if (e < tgt)
          e = (e + dl > tgt) ? tgt : e + dl;
        else
          e = (e - dl < tgt) ? tgt : e - dl;
        chk(16'(code[ch]), 16'(e));
        if (cnt > 1)
          chk(16'(gap), 16'(per));
        gap = 0;
        prev = code[ch];
      end
      if (n > 1 && busy[ch] !== 1'b1)
        break;
    end
    chk(16'(code[ch]), 16'(tgt));
  endtask
  // Hang guard, well beyond the expected run.
  initial
  begin
    #(25 * 20000);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    // Reset values, read back, and an unmapped address.
    for (int i = 0; i < NUM_CH; i++)
    begin
      h.rd(CFG_ADDR[i], d, v);
      chk(d, CFG_RST);
      chk(16'(v), 16'h0001);
      h.wr(CFG_ADDR[i], 16'hE700 | 16'(i << 4));
      h.rd(CFG_ADDR[i], d, v);
      chk(d, 16'hE700 | 16'(i << 4));
    end
    h.rd(8'h30, d, v);
    chk(d, 16'h0000);
    $display("register test done");
    h.wr(CFG_ADDR[0], 16'h0700);
    h.wr(DATA_ADDR[0], 16'hABC0);
    chk(16'(code[0]), 16'h0ABC);
    h.wr(CFG_ADDR[0], 16'h4700);
    h.wr(DATA_ADDR[0], 16'h1230);
    chk(16'(code[0]), 16'h0ABC);
    h.pin(0);
    chk(16'(code[0]), 16'h0123);
    h.wr(DATA_ADDR[0], 16'h4560);
    h.wr(TRIG_ADDR, 16'h0080);
    @(posedge clk);
    #1;
    chk(16'(code[0]), 16'h0456);
    h.rd(TRIG_ADDR, d, v);
    chk(d, 16'h0000);
    $display("update test done");
    h.wr(CFG_ADDR[1], 16'h2700);
    h.wr(CFG_ADDR[2], 16'h0700);
    h.brd(12'h5A5);
    chk(16'(code[1]), 16'h05A5);
    chk(16'(code[2]), 16'h0000);
    chk(16'(code[0]), 16'h0456);
    $display("broadcast test done");
    h.wr(CFG_ADDR[0], 16'h8700);
    h.pin(1);
    chk(16'(code[0]), 16'h0800);
    chk(16'(code[1]), 16'h0000);
    h.wr(DATA_ADDR[1], 16'h1110);
    h.wr(TRIG_ADDR, 16'h0040);
    @(posedge clk);
    #1;
    chk(16'(code[1]), 16'h0000);
    chk(16'(code[0]), 16'h0800);
    $display("clear test done");
    // Linear slew, 16-code steps every 4 cycles, last step clamped.
    h.wr(CFG_ADDR[3], 16'h0761);
    h.marg(3, 12'h000, 12'h035, 1'b1);
    track(3, 16'h035, 16, 4);
    h.wr(CFG_ADDR[3], 16'h0760);
    h.marg(3, 12'h000, 12'h035, 1'b0);
    @(posedge clk);
    @(posedge clk);
    #1;
    chk(16'(code[3]), 16'h0000);
    chk(16'(busy[3]), 16'h0000);
    $display("linear slew test done");
    // Log slew up from zero on rise timing, then down on fall timing.
    h.wr(CFG_ADDR[2], 16'h0782);
    h.marg(2, 12'h000, 12'h050, 1'b1);
    track(2, 16'h050, 0, 4);
    h.marg(2, 12'h010, 12'h050, 1'b0);
    track(2, 16'h010, 0, 12);
    h.wr(CFG_ADDR[2], 16'h0901);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(code[2]), 16'h0025);
    $display("log slew test done");
    wrap_up();
  end
endmodule
